// ===== logic/vxws_responder.sv
// vxws_responder: word serial command interpreter behind the lower data word register
// assumes the register access strobes come from the backplane decoder on clk_i
`timescale 1ns/1ns
module vxws_responder
  import vxws_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        cmd_wr_i,      // write strobe to command_data_word
  input  wire logic [15:0] cmd_data_i,    // word written
  input  wire logic        data_rd_i,     // read strobe of command_data_word
  input  wire logic        rqs_set_i,     // request true interrupt generated
  output logic      [15:0] status_o,      // handshake_status
  output logic      [15:0] data_o,        // command_data_word read value
  output logic             locked_o       // lock state
);

  // whole controller state in one register
  typedef struct packed {
    vxws_state_t state;
    logic [15:0] cmd;
    logic [15:0] reply;
    logic        rr;
    logic        lock;
    logic        rqs;
    logic [15:0] status;
  } vxws_regs_t;

  vxws_regs_t r_reg;
  vxws_regs_t r_next;

  // assemble the handshake status word
  function automatic logic [15:0] mk_status(input logic rr, input logic wr, input logic lock);
    logic [15:0] s;
    s = STAT_RESET;
    s[STAT_RR_BIT]   = rr;
    s[STAT_WR_BIT]   = wr;
    s[STAT_LOCK_BIT] = lock;
    return s;
  endfunction

  // next-state logic
  always_comb begin
    r_next = r_reg;
    if (r_reg.state == VXWS_IDLE) begin
      if (data_rd_i && r_reg.rr) begin
        r_next.rr = 1'b0;
      end
      if (cmd_wr_i) begin
        r_next.cmd   = cmd_data_i;
        r_next.state = VXWS_EXEC;
      end
    end
    case (r_reg.state)
      VXWS_IDLE: begin
      end
      // one execute cycle, write ready low meanwhile
      VXWS_EXEC: begin
        r_next.state = VXWS_IDLE;
        case (r_reg.cmd)
          CMD_READ_PROTOCOL: begin
            r_next.reply = PROTOCOL_REPLY;
            r_next.rr    = 1'b1;
          end
          CMD_BYTE_REQUEST: begin
            r_next.reply = BYTE_REPLY;
            r_next.rr    = 1'b1;
          end
          CMD_SET_LOCK: begin
            r_next.lock = 1'b1;
          end
          CMD_CLEAR_LOCK: begin
            r_next.lock = 1'b0;
          end
          CMD_READ_STB: begin
            r_next.reply = {STB_UPPER, 1'b0, r_reg.rqs, 6'h00};
            r_next.rqs   = 1'b0;
            r_next.rr    = 1'b1;
          end
          // async mode control words (upper byte CMD_ASYNC_HI) get a reply and read ready; other words accepted, no effect
          default: begin
            if (r_reg.cmd[15:8] == CMD_ASYNC_HI) begin
              if (r_reg.cmd[1] || r_reg.cmd[0]) begin
                r_next.reply = {ASYNC_FAIL, 12'h000};
              end else begin
                r_next.reply = {ASYNC_OK, 8'h00, r_reg.cmd[3:2], 2'b00};
              end
              r_next.rr = 1'b1;
            end
          end
        endcase
      end
      default: begin
        r_next.state = VXWS_IDLE;
      end
    endcase
    // request flag: a new request beats the clearing query
    if (rqs_set_i) begin
      r_next.rqs = 1'b1;
    end
    r_next.status = mk_status(r_next.rr, r_next.state == VXWS_IDLE, r_next.lock);
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg.state  <= VXWS_IDLE;
      r_reg.cmd    <= DATA_RESET;
      r_reg.reply  <= DATA_RESET;
      r_reg.rr     <= 1'b0;
      r_reg.lock   <= 1'b0;
      r_reg.rqs    <= 1'b0;
      r_reg.status <= STAT_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flip-flops
  // single 16-bit data word
  assign data_o   = r_reg.reply;
  // fast handshake bit held in status word
  assign status_o = r_reg.status;
  assign locked_o = r_reg.lock;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // a write the controller takes this cycle
  logic wr_taken;
  assign wr_taken = cmd_wr_i && status_o[STAT_WR_BIT];

  property p_rr_set;
    wr_taken && (cmd_data_i == CMD_BYTE_REQUEST) |-> ##2 status_o[STAT_RR_BIT] && data_o == BYTE_REPLY;
  endproperty
  a_rr_set: assert property (p_rr_set) else $error("read ready not set after byte request");

  property p_rr_clr;
    data_rd_i && status_o[STAT_RR_BIT] && status_o[STAT_WR_BIT] && !cmd_wr_i |-> ##1 !status_o[STAT_RR_BIT];
  endproperty
  a_rr_clr: assert property (p_rr_clr) else $error("read ready not cleared after read");

  property p_fhs;
    status_o[STAT_FHS_BIT] && !status_o[STAT_ZERO_BIT];
  endproperty
  a_fhs: assert property (p_fhs) else $error("fast handshake bit not one");

  property p_lock;
    wr_taken && (cmd_data_i == CMD_SET_LOCK) |-> ##2 status_o[STAT_LOCK_BIT] && locked_o;
  endproperty
  a_lock: assert property (p_lock) else $error("lock bit not set");

  property p_unlock;
    wr_taken && (cmd_data_i == CMD_CLEAR_LOCK) |-> ##2 !status_o[STAT_LOCK_BIT];
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock bit not cleared");

  property p_proto;
    wr_taken && (cmd_data_i == CMD_READ_PROTOCOL) |-> ##2 data_o == 16'hFE6B && status_o[STAT_RR_BIT];
  endproperty
  a_proto: assert property (p_proto) else $error("wrong protocol reply");

  property p_stb;
    wr_taken && (cmd_data_i == CMD_READ_STB) && r_reg.rqs |-> ##2 data_o == 16'hFF40;
  endproperty
  a_stb: assert property (p_stb) else $error("wrong status byte reply");

  property p_stb_clr;
    r_reg.state == VXWS_EXEC && r_reg.cmd == CMD_READ_STB && !rqs_set_i |-> ##1 !r_reg.rqs;
  endproperty
  a_stb_clr: assert property (p_stb_clr) else $error("request flag not cleared");

  property p_async_fail;
    wr_taken && cmd_data_i[15:8] == CMD_ASYNC_HI && |cmd_data_i[1:0] |-> ##2 data_o[15:12] == 4'h7;
  endproperty
  a_async_fail: assert property (p_async_fail) else $error("async failure status wrong");

  property p_async_ok;
    wr_taken && cmd_data_i[15:8] == CMD_ASYNC_HI && cmd_data_i[1:0] == 2'b00
      |-> ##2 data_o[15:12] == 4'hF && data_o[3:2] == $past(cmd_data_i[3:2], 2) && data_o[1:0] == 2'b00;
  endproperty
  a_async_ok: assert property (p_async_ok) else $error("async success reply wrong");

  property p_busy;
    wr_taken |-> ##1 !status_o[STAT_WR_BIT] ##1 status_o[STAT_WR_BIT];
  endproperty
  a_busy: assert property (p_busy) else $error("write ready timing wrong");

  // protocol reply field by field, so a bad constant names the broken rule
  property p_proto_hi;
    wr_taken && (cmd_data_i == CMD_READ_PROTOCOL) |-> ##2 data_o[15:9] == 7'h7F;
  endproperty
  a_proto_hi: assert property (p_proto_hi) else $error("protocol reply upper bits wrong");

  property p_proto_zero;
    wr_taken && (cmd_data_i == CMD_READ_PROTOCOL)
      |-> ##2 !data_o[8] && !data_o[7] && !data_o[4] && !data_o[2];
  endproperty
  a_proto_zero: assert property (p_proto_zero) else $error("protocol reply zero bits wrong");

  property p_proto_one;
    wr_taken && (cmd_data_i == CMD_READ_PROTOCOL)
      |-> ##2 data_o[6:5] == 2'b11 && data_o[3] && data_o[1:0] == 2'b11;
  endproperty
  a_proto_one: assert property (p_proto_one) else $error("protocol reply one bits wrong");

  // read ready: set only by an execute cycle, held until a taken read
  property p_reply_rr;
    wr_taken && (cmd_data_i == CMD_READ_STB || cmd_data_i[15:8] == CMD_ASYNC_HI)
      |-> ##2 status_o[STAT_RR_BIT];
  endproperty
  a_reply_rr: assert property (p_reply_rr) else $error("read ready not set after query");

  property p_rr_hold;
    status_o[STAT_RR_BIT] && !(data_rd_i && status_o[STAT_WR_BIT]) |-> ##1 status_o[STAT_RR_BIT];
  endproperty
  a_rr_hold: assert property (p_rr_hold) else $error("read ready dropped with reply unread");

  property p_rr_rise;
    $rose(status_o[STAT_RR_BIT]) |-> $past(r_reg.state == VXWS_EXEC);
  endproperty
  a_rr_rise: assert property (p_rr_rise) else $error("read ready set outside execution");

  // lock: mirrored in the status word, moved only by the two lock commands
  property p_lock_mirror;
    status_o[STAT_LOCK_BIT] == locked_o;
  endproperty
  a_lock_mirror: assert property (p_lock_mirror) else $error("lock bit and lock output differ");

  property p_lock_hold;
    $changed(locked_o)
      |-> $past(r_reg.state == VXWS_EXEC && (r_reg.cmd == CMD_SET_LOCK || r_reg.cmd == CMD_CLEAR_LOCK));
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock changed without lock command");

  property p_lock_quiet;
    wr_taken && (cmd_data_i == CMD_SET_LOCK || cmd_data_i == CMD_CLEAR_LOCK) && !status_o[STAT_RR_BIT]
      |-> ##2 !status_o[STAT_RR_BIT];
  endproperty
  a_lock_quiet: assert property (p_lock_quiet) else $error("lock command raised read ready");

  // status image and pacing of the controller
  property p_status_fixed;
    (status_o & 16'hF97F) == 16'h4900;
  endproperty
  a_status_fixed: assert property (p_status_fixed) else $error("fixed status bits wrong");

  property p_wr_mirror;
    status_o[STAT_WR_BIT] == (r_reg.state == VXWS_IDLE);
  endproperty
  a_wr_mirror: assert property (p_wr_mirror) else $error("write ready and controller state differ");

  property p_exec_once;
    r_reg.state == VXWS_EXEC |-> ##1 r_reg.state == VXWS_IDLE;
  endproperty
  a_exec_once: assert property (p_exec_once) else $error("execute phase longer than one cycle");

  property p_busy_refused;
    cmd_wr_i && !status_o[STAT_WR_BIT] |-> ##1 $stable(r_reg.cmd);
  endproperty
  a_busy_refused: assert property (p_busy_refused) else $error("write taken while busy");

  // reply word and request flag
  property p_data_hold;
    $changed(data_o) |-> $past(r_reg.state == VXWS_EXEC);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("reply word changed outside execution");

  property p_rqs_set;
    rqs_set_i |-> ##1 r_reg.rqs;
  endproperty
  a_rqs_set: assert property (p_rqs_set) else $error("request flag not set");

  c_proto: cover property (wr_taken && cmd_data_i == CMD_READ_PROTOCOL ##2 data_rd_i);
  c_stb:   cover property (rqs_set_i ##[1:20] wr_taken && cmd_data_i == CMD_READ_STB);
  c_async: cover property (wr_taken && cmd_data_i[15:8] == CMD_ASYNC_HI);
  c_lock:  cover property (wr_taken && cmd_data_i == CMD_SET_LOCK ##[3:30] wr_taken && cmd_data_i == CMD_CLEAR_LOCK);
  c_rqs_race: cover property (r_reg.state == VXWS_EXEC && r_reg.cmd == CMD_READ_STB && rqs_set_i);

endmodule // vxws_responder

// ===== logic/vxws_pkg.sv
// vxws_pkg: constants for the word serial responder of a message-based servant
// assumes a 16-bit lower data word register and a 16-bit handshake status register
package vxws_pkg;

  localparam int unsigned VXWS_W = 16;

  // handshake_status field positions
  localparam int unsigned STAT_ZERO_BIT = 15;  // defined value 0
  localparam int unsigned STAT_RSVD_BIT = 14;  // reserved, reads 1
  localparam int unsigned STAT_DOR_BIT  = 13;  // data out ready, unused here
  localparam int unsigned STAT_DIR_BIT  = 12;  // data in ready, unused here
  localparam int unsigned STAT_ERRN_BIT = 11;  // no error when 1
  localparam int unsigned STAT_RR_BIT   = 10;  // read ready
  localparam int unsigned STAT_WR_BIT   = 9;   // write ready
  localparam int unsigned STAT_FHS_BIT  = 8;   // fast handshake active
  localparam int unsigned STAT_LOCK_BIT = 7;   // locked

  // handshake_status value after reset: reserved and error-free set, write ready, fast handshake
  localparam logic [15:0] STAT_RESET = 16'h4B00;

  // command words
  localparam logic [15:0] CMD_READ_PROTOCOL = 16'hDFFF;
  localparam logic [15:0] CMD_BYTE_REQUEST  = 16'hDEFF;
  localparam logic [15:0] CMD_SET_LOCK      = 16'hEFFF;
  localparam logic [15:0] CMD_CLEAR_LOCK    = 16'hEEFF;
  localparam logic [15:0] CMD_READ_STB      = 16'hCFFF;
  localparam logic [7:0]  CMD_ASYNC_HI      = 8'hA8;   // upper byte of async mode control

  // replies
  localparam logic [15:0] PROTOCOL_REPLY    = 16'hFE6B;
  localparam logic [7:0]  STB_UPPER         = 8'hFF;
  localparam int unsigned STB_RQS_BIT       = 6;
  localparam logic [3:0]  ASYNC_OK          = 4'hF;
  localparam logic [3:0]  ASYNC_FAIL        = 4'h7;
  localparam logic [15:0] BYTE_REPLY        = 16'h0100;  // end flag set, data byte zero
  localparam logic [15:0] DATA_RESET        = 16'h0000;

  // controller states
  typedef enum logic [0:0] {
    VXWS_IDLE = 1'b0,
    VXWS_EXEC = 1'b1
  } vxws_state_t;

endpackage : vxws_pkg

// ===== test/vxws_commander.sv
// vxws_commander: behavioural commander issuing word serial commands
// assumes the responder samples its strobes on the rising edge of clk_i
`timescale 1ns/1ns
module vxws_commander (
  input  wire logic        clk_i,
  input  wire logic [15:0] status_i,
  input  wire logic [15:0] data_i,
  output logic             cmd_wr_o,
  output logic      [15:0] cmd_data_o,
  output logic             data_rd_o
);
  initial begin
    cmd_wr_o   = 1'b0;
    cmd_data_o = 16'h0000;
    data_rd_o  = 1'b0;
  end
  // bounded wait for a status bit at falling edges
  task automatic wait_bit(input int b, output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(negedge clk_i);
      ok = (status_i[b] === 1'b1);
    end
  endtask
  task automatic send(input logic [15:0] w, output bit ok);
    wait_bit(9, ok);
    cmd_data_o = w;
    cmd_wr_o   = 1'b1;
    @(negedge clk_i);
    cmd_wr_o   = 1'b0;
    cmd_data_o = ~w;  // stale data never looks valid
  endtask
  task automatic fetch(output logic [15:0] r, output bit ok);
    wait_bit(10, ok);
    r         = data_i;
    data_rd_o = 1'b1;
    @(negedge clk_i);
    data_rd_o = 1'b0;
  endtask
endmodule // vxws_commander

// ===== test/vxws_responder_tb_top.sv
// vxws_responder_tb_top: self-checking bench of the word serial responder
// assumes the commander model in vxws_commander.sv
`timescale 1ns/1ns
module vxws_responder_tb_top;
  import vxws_pkg::*;
  logic        clk_i, rst_n_i, cmd_wr_i, data_rd_i, rqs_set_i, locked_o;
  logic [15:0] cmd_data_i, status_o, data_o;
  int          mismatches, tests_run;
  bit          ok;
  logic [15:0] c;

  vxws_responder dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_wr_i(cmd_wr_i), .cmd_data_i(cmd_data_i),
    .data_rd_i(data_rd_i), .rqs_set_i(rqs_set_i), .status_o(status_o), .data_o(data_o), .locked_o(locked_o));
  vxws_commander cmdr_u (.clk_i(clk_i), .status_i(status_o), .data_i(data_o), .cmd_wr_o(cmd_wr_i),
    .cmd_data_o(cmd_data_i), .data_rd_o(data_rd_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // expected replies
  function automatic logic [15:0] stb_exp(input logic rqs);
    return {8'hFF, 1'b0, rqs, 6'h00};
  endfunction
  function automatic logic [15:0] async_exp(input logic [15:0] w);
    return (w[1:0] != 2'b00) ? 16'h7000 : {4'hF, 8'h00, w[3:2], 2'b00};
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic need(input bit k);
    if (!k) begin
      mismatches++;
      $display("mismatch at %0t: wait ran out", $time);
      final_report();
    end
  endtask
  // command with readback, then the read
  task automatic query(input logic [15:0] w, input logic [15:0] exp);
    logic [15:0] r;
    cmdr_u.send(w, ok);                      // write when ready
    need(ok);                                // write ready seen
    chk({15'h0000, status_o[9]}, 16'h0000);  // busy while executing
    cmdr_u.fetch(r, ok);                     // read when ready
    need(ok);                                // read ready set
    chk(r, exp);                             // reply content
    chk({15'h0000, status_o[10]}, 16'h0000); // cleared after read
  endtask
  // command without readback, then status
  task automatic plain(input logic [15:0] w, input logic [15:0] exp);
    cmdr_u.send(w, ok);     // write when ready
    need(ok);               // write ready seen
    cmdr_u.wait_bit(9, ok); // execution over
    need(ok);               // write ready back
    chk(status_o, exp); // no readback
  endtask

  initial begin
    rst_n_i   = 1'b0;
    rqs_set_i = 1'b0;
    mismatches = 0;
    tests_run  = 0;
    void'($urandom(32'h792C0EFA));
    repeat (4) @(negedge clk_i);
    chk(status_o, 16'h4B00); // reset status
    chk(data_o, 16'h0000);   // data word reset
    rst_n_i = 1'b1;
    query(CMD_READ_PROTOCOL, 16'hFE6B);
    query(CMD_BYTE_REQUEST, 16'h0100);  // byte request
    @(negedge clk_i);
    rqs_set_i = 1'b1;
    @(negedge clk_i);
    rqs_set_i = 1'b0;
    query(CMD_READ_STB, stb_exp(1'b1)); // flag reported
    query(CMD_READ_STB, stb_exp(1'b0)); // flag cleared
    // request in the query's execute cycle: set beats clear
    cmdr_u.send(CMD_READ_STB, ok); // write when ready
    need(ok);                      // write ready seen
    rqs_set_i = 1'b1;
    @(negedge clk_i);
    rqs_set_i = 1'b0;
    cmdr_u.fetch(c, ok);           // read when ready
    need(ok);                      // read ready set
    chk(c, stb_exp(1'b0));         // old flag reported
    query(CMD_READ_STB, stb_exp(1'b1)); // flag kept
    plain(CMD_SET_LOCK, 16'h4B80);      // lock set
    chk({15'h0000, locked_o}, 16'h0001); // lock output
    plain(16'h1234, 16'h4B80);          // unknown word
    plain(CMD_CLEAR_LOCK, 16'h4B00);    // lock cleared
    chk({15'h0000, locked_o}, 16'h0000); // lock output
    // every low nibble of async mode control, random middle bits
    for (int i = 0; i < 32; i++) begin
      c = {CMD_ASYNC_HI, 4'($urandom), 4'(i)};
      query(c, async_exp(c));
    end
    // reset in mid-run with lock set and a reply unread
    plain(CMD_SET_LOCK, 16'h4B80);       // lock set again
    cmdr_u.send(CMD_BYTE_REQUEST, ok);   // write when ready
    need(ok);                            // write ready seen
    cmdr_u.wait_bit(10, ok);             // reply pending
    need(ok);                            // read ready set
    rst_n_i = 1'b0;
    @(negedge clk_i);
    chk(status_o, STAT_RESET);           // flags cleared by reset
    chk(data_o, DATA_RESET);             // reply word cleared
    chk({15'h0000, locked_o}, 16'h0000); // lock output cleared
    rst_n_i = 1'b1;
    query(CMD_READ_PROTOCOL, 16'hFE6B);  // first write after release
    final_report();
  end
endmodule // vxws_responder_tb_top
